// ==== rtl/asc_pkg.sv ====
package asc_pkg;

  // ---------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;

  // ---------------------------------------------------------------
  // Timing of the memory, in ns, and the clock
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 50;
  localparam int T_READ_CYCLE_NS = 45;
  localparam int T_ADDR_ACCESS   = 45;
  localparam int T_CE_ACCESS     = 45;
  localparam int T_OE_ACCESS     = 22;
  localparam int T_BE_ACCESS     = 22;
  localparam int T_WRITE_CYCLE   = 45;
  localparam int T_WRITE_PULSE   = 35;
  localparam int T_DATA_SETUP    = 25;
  localparam int T_FLOAT_DELAY   = 18;
  localparam int T_DATA_HOLD     = 0;

  function automatic int cyc_min(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // Least counts, rounded up to whole cycles
  localparam int RD_ACCESS_CYC = cyc_min(T_ADDR_ACCESS);
  localparam int WR_PULSE_CYC  = cyc_min(T_WRITE_PULSE);
  localparam int WR_FLOAT_CYC  = cyc_min(T_FLOAT_DELAY);
  localparam int WR_SETUP_CYC  = cyc_min(T_DATA_SETUP);
  localparam int WR_LOW_CYC    = cyc_min(T_DATA_SETUP + T_FLOAT_DELAY);
  localparam int CYCLE_CYC     = cyc_min(T_READ_CYCLE_NS);
  localparam int CNT_W         = 4;

  // ---------------------------------------------------------------
  // Reset values of the bus pins
  // ---------------------------------------------------------------
  localparam logic RST_INACTIVE_N = 1'h1;

endpackage

// ==== rtl/asc_sync.sv ====
`timescale 1ns/100ps
`default_nettype none

module asc_sync #(
  parameter int WIDTH = 16
) (
  input  wire logic             ref_clk_in,
  input  wire logic             reset_in,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // The first stage feeds only the second stage
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule

`default_nettype wire

// ==== rtl/asc_host.sv ====
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// [RL1] Memory stores lane when strobe, select, lane low
// [RL2] All qualifiers active before write; one ends it
// [RL3] Data stable 25 ns before write end
// [RL4] Sample read no earlier than 45 ns after address
// [RL5] Memory holds old data 10 ns after address
// [RL6] Sample no earlier than 45 ns after select
// [RL7] Sample no earlier than 22 ns after output enable
// [RL8] Sample lane no earlier than 22 ns after lane select
// [RL9] Address stable through write, 35 ns setup
// [RL10] Select, strobe, lanes low 35 ns before end
// [RL11] Strobe pulse at least setup plus float delay
// [RL12] Memory floats data when output enable high
// [RL13] Memory floats when select and strobe rise together
// [RL14] Host drives data only after 18 ns float delay
// [RL15] Memory powers down 45 ns after deselect
// [RL16] Each cycle lasts at least minimum cycle time
// [RL17] Lower select bits 0-7, upper bits 8-15
module asc_host #(
  parameter int ADDR_W = asc_pkg::ADDR_W,
  parameter int DATA_W = asc_pkg::DATA_W
) (
  input  wire logic              ref_clk_in,
  input  wire logic              reset_in,
  input  wire logic              req_valid_in,
  input  wire logic              req_write_in,
  input  wire logic [ADDR_W-1:0] req_addr_in,
  input  wire logic [DATA_W-1:0] req_wdata_in,
  input  wire logic [1:0]        req_lanes_in,
  output logic                   req_ready_out,
  output logic                   rsp_valid_out,
  output logic [DATA_W-1:0]      rsp_rdata_out,
  output logic [ADDR_W-1:0]      mem_addr_out,
  output logic                   chip_sel_n_out,
  output logic                   write_strobe_n_out,
  output logic                   out_enable_n_out,
  output logic                   upper_byte_sel_n_out,
  output logic                   lower_byte_sel_n_out,
  input  wire logic [DATA_W-1:0] mem_data_in,
  output logic [DATA_W-1:0]      mem_data_out,
  output logic                   mem_data_oe_out
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ASC_IDLE,
    ASC_RD_WAIT,
    ASC_RD_SAMPLE,
    ASC_WR_FLOAT,
    ASC_WR_PULSE,
    ASC_WR_END,
    ASC_RECOVER
  } asc_state_t;

  asc_state_t                    state_q, state_d;
  logic [asc_pkg::CNT_W-1:0]     cnt_q, cnt_d;
  logic [ADDR_W-1:0]             addr_q, addr_d;
  logic [DATA_W-1:0]             wdata_q, wdata_d;
  logic                          cs_n_q, cs_n_d;
  logic                          we_n_q, we_n_d;
  logic                          oe_n_q, oe_n_d;
  logic                          ub_n_q, ub_n_d;
  logic                          lb_n_q, lb_n_d;
  logic                          doe_q, doe_d;
  logic                          rdy_q, rdy_d;
  logic                          rv_q, rv_d;
  logic [DATA_W-1:0]             rdata_q, rdata_d;
  logic [DATA_W-1:0]             data_sync;
  logic [DATA_W-1:0]             lane_mask;

  // ---------------------------------------------------------------
  // Read data passes two flip-flops before use
  // ---------------------------------------------------------------
  asc_sync #(.WIDTH(DATA_W)) u_sync (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .async_in   (mem_data_in),
    .sync_out   (data_sync)
  );

  // Lower select covers bits 7:0, upper select bits 15:8
  assign lane_mask = {{(DATA_W/2){~ub_n_q}}, {(DATA_W/2){~lb_n_q}}}; // RL17

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    addr_d  = addr_q;
    wdata_d = wdata_q;
    cs_n_d  = cs_n_q;
    we_n_d  = we_n_q;
    oe_n_d  = oe_n_q;
    ub_n_d  = ub_n_q;
    lb_n_d  = lb_n_q;
    doe_d   = doe_q;
    rdy_d   = rdy_q;
    rv_d    = 1'b0;
    rdata_d = rdata_q;
    unique case (state_q)
      ASC_IDLE: begin
        if (!rdy_q) begin
          // Ready comes up on the first edge out of reset
          rdy_d = 1'b1;
        end
        if (req_valid_in && rdy_q && (req_lanes_in != 2'h0)) begin
          rdy_d   = 1'b0;
          addr_d  = req_addr_in;
          wdata_d = req_wdata_in;
          cs_n_d  = 1'b0;
          ub_n_d  = ~req_lanes_in[1];
          lb_n_d  = ~req_lanes_in[0];
          cnt_d   = '0;
          if (req_write_in) begin
            // Output enable stays high so the memory never drives
            oe_n_d  = 1'b1; // RL12
            we_n_d  = 1'b0; // RL2
            state_d = ASC_WR_FLOAT;
          end else begin
            oe_n_d  = 1'b0;
            state_d = ASC_RD_WAIT;
          end
        end
      end
      ASC_RD_WAIT: begin
        // Extra cycles also cover the two-stage capture latency
        cnt_d = cnt_q + 1'b1;
        if (cnt_q >= asc_pkg::CNT_W'(asc_pkg::RD_ACCESS_CYC + 1)) begin // RL4 RL6 RL7 RL8
          state_d = ASC_RD_SAMPLE;
        end
      end
      ASC_RD_SAMPLE: begin
        rdata_d = data_sync & lane_mask; // RL17
        rv_d    = 1'b1;
        cs_n_d  = 1'b1;
        oe_n_d  = 1'b1;
        ub_n_d  = 1'b1;
        lb_n_d  = 1'b1;
        cnt_d   = '0;
        state_d = ASC_RECOVER;
      end
      ASC_WR_FLOAT: begin
        // Bus released by the memory before the host drives it
        cnt_d = cnt_q + 1'b1;
        if (cnt_q + 1'b1 >= asc_pkg::CNT_W'(asc_pkg::WR_FLOAT_CYC)) begin // RL14
          doe_d   = 1'b1;
          cnt_d   = '0;
          state_d = ASC_WR_PULSE;
        end
      end
      ASC_WR_PULSE: begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q + 1'b1 >= asc_pkg::CNT_W'(asc_pkg::WR_SETUP_CYC)
            && cnt_q + 1'b1 >= asc_pkg::CNT_W'(asc_pkg::WR_PULSE_CYC)) begin // RL3 RL10 RL11
          // Strobe terminates the write; address and data held past it
          we_n_d  = 1'b1; // RL2 RL9
          state_d = ASC_WR_END;
        end
      end
      ASC_WR_END: begin
        cs_n_d  = 1'b1;
        ub_n_d  = 1'b1;
        lb_n_d  = 1'b1;
        doe_d   = 1'b0;
        cnt_d   = '0;
        state_d = ASC_RECOVER;
      end
      ASC_RECOVER: begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q + 1'b1 >= asc_pkg::CNT_W'(asc_pkg::CYCLE_CYC)) begin // RL16
          rdy_d   = 1'b1;
          state_d = ASC_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      state_q <= ASC_IDLE;
      cnt_q   <= '0;
      addr_q  <= '0;
      wdata_q <= '0;
      cs_n_q  <= asc_pkg::RST_INACTIVE_N;
      we_n_q  <= asc_pkg::RST_INACTIVE_N;
      oe_n_q  <= asc_pkg::RST_INACTIVE_N;
      ub_n_q  <= asc_pkg::RST_INACTIVE_N;
      lb_n_q  <= asc_pkg::RST_INACTIVE_N;
      doe_q   <= 1'b0;
      rdy_q   <= 1'b0;
      rv_q    <= 1'b0;
      rdata_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      addr_q  <= addr_d;
      wdata_q <= wdata_d;
      cs_n_q  <= cs_n_d;
      we_n_q  <= we_n_d;
      oe_n_q  <= oe_n_d;
      ub_n_q  <= ub_n_d;
      lb_n_q  <= lb_n_d;
      doe_q   <= doe_d;
      rdy_q   <= rdy_d;
      rv_q    <= rv_d;
      rdata_q <= rdata_d;
    end
  end

  assign req_ready_out        = rdy_q;
  assign rsp_valid_out        = rv_q;
  assign rsp_rdata_out        = rdata_q;
  assign mem_addr_out         = addr_q;
  assign chip_sel_n_out       = cs_n_q;
  assign write_strobe_n_out   = we_n_q;
  assign out_enable_n_out     = oe_n_q;
  assign upper_byte_sel_n_out = ub_n_q;
  assign lower_byte_sel_n_out = lb_n_q;
  assign mem_data_out         = wdata_q;
  assign mem_data_oe_out      = doe_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_strobe_pulse_len: assert property (@(posedge ref_clk_in) disable iff (reset_in) // RL11
    $fell(we_n_q) |-> !we_n_q [*2]) else $error("write strobe pulse too short");

  chk_no_drive_early: assert property (@(posedge ref_clk_in) disable iff (reset_in) // RL14
    $fell(we_n_q) |-> !doe_q) else $error("host drove data as strobe fell");

  chk_data_setup: assert property (@(posedge ref_clk_in) disable iff (reset_in) // RL3
    $rose(we_n_q) |-> doe_q && $past(doe_q, 1)) else $error("data setup too short");

  chk_addr_hold: assert property (@(posedge ref_clk_in) disable iff (reset_in) // RL9
    !we_n_q |=> $stable(addr_q)) else $error("address moved during write");

  chk_write_qualify: assert property (@(posedge ref_clk_in) disable iff (reset_in) // RL2
    $fell(we_n_q) |-> !cs_n_q && (!ub_n_q || !lb_n_q)) else $error("write without select");

  chk_select_width: assert property (@(posedge ref_clk_in) disable iff (reset_in) // RL10
    $rose(we_n_q) |-> !cs_n_q && $past(!cs_n_q, 2)) else $error("select held too short");

  chk_read_access: assert property (@(posedge ref_clk_in) disable iff (reset_in) // RL4
    rv_q |-> $past(!oe_n_q, 3) && $past(!cs_n_q, 3)) else $error("read sampled too early");

  chk_oe_in_write: assert property (@(posedge ref_clk_in) disable iff (reset_in) // RL12
    doe_q |-> oe_n_q) else $error("output enable low while host drives");

  chk_cycle_space: assert property (@(posedge ref_clk_in) disable iff (reset_in) // RL16
    $rose(cs_n_q) |=> cs_n_q) else $error("cycle spacing too short");

  chk_write_lanes: assert property (@(posedge ref_clk_in) disable iff (reset_in) // RL2
    !we_n_q |-> !cs_n_q && (!ub_n_q || !lb_n_q)) else $error("strobe low without select");

  chk_float_gap: assert property (@(posedge ref_clk_in) disable iff (reset_in) // RL14
    $rose(doe_q) |-> $past(!we_n_q) && $past(oe_n_q)) else $error("host drove before float");

  chk_release_end: assert property (@(posedge ref_clk_in) disable iff (reset_in) // RL3
    $rose(we_n_q) |-> $stable(wdata_q) && $stable(addr_q) && !cs_n_q)
    else $error("data or address moved at write end");

  chk_data_settled: assert property (@(posedge ref_clk_in) disable iff (reset_in) // RL3
    doe_q |-> $stable(wdata_q)) else $error("write data moved while driven");

  chk_addr_read: assert property (@(posedge ref_clk_in) disable iff (reset_in) // RL4
    !oe_n_q |=> $stable(addr_q)) else $error("address moved during read");

  chk_read_no_drive: assert property (@(posedge ref_clk_in) disable iff (reset_in) // RL14
    !oe_n_q |-> we_n_q && !doe_q) else $error("host drove during read");

  chk_lane_access: assert property (@(posedge ref_clk_in) disable iff (reset_in) // RL8
    rv_q |-> $past(!ub_n_q || !lb_n_q, 4)) else $error("lane sampled too early");

  chk_upper_mask: assert property (@(posedge ref_clk_in) disable iff (reset_in) // RL17
    rv_q && $past(ub_n_q) |-> rdata_q[DATA_W-1:DATA_W/2] == '0)
    else $error("disabled upper lane not zero");

  chk_lower_mask: assert property (@(posedge ref_clk_in) disable iff (reset_in) // RL17
    rv_q && $past(lb_n_q) |-> rdata_q[DATA_W/2-1:0] == '0)
    else $error("disabled lower lane not zero");

  chk_ready_idle: assert property (@(posedge ref_clk_in) disable iff (reset_in) // RL16
    rdy_q |-> state_q == ASC_IDLE) else $error("ready outside idle");

  // ---------------------------------------------------------------
  // Strobe width watch
  // ---------------------------------------------------------------
  // Saturates rather than wraps, so a long pulse never looks short
  logic [asc_pkg::CNT_W-1:0]     low_q, low_d;

  always_comb begin
    low_d = '0;
    if (!we_n_q) begin
      low_d = (low_q == '1) ? low_q : low_q + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      low_q <= '0;
    end else begin
      low_q <= low_d;
    end
  end

  chk_strobe_low_cnt: assert property (@(posedge ref_clk_in) disable iff (reset_in) // RL11
    $rose(we_n_q) |-> low_q >= asc_pkg::CNT_W'(asc_pkg::WR_LOW_CYC))
    else $error("strobe low time below setup plus float");

endmodule

`default_nettype wire

// ==== verif/asc_sram_model.sv ====
`timescale 1ns/100ps
`default_nettype none

module asc_sram_model (
  input  wire logic [17:0] addr_in,
  input  wire logic        chip_sel_n_in,
  input  wire logic        write_strobe_n_in,
  input  wire logic        out_enable_n_in,
  input  wire logic        upper_byte_sel_n_in,
  input  wire logic        lower_byte_sel_n_in,
  input  wire logic [15:0] dq_in,
  output logic      [15:0] dq_out
);
  // ---------------------------------------------------------------
  // Storage and bus drive
  // ---------------------------------------------------------------
  logic [15:0] mem [logic [17:0]];
  logic [17:0] addr_d;
  logic [15:0] word;
  logic [15:0] last_q = 16'h0000;
  logic        valid_q = 1'b0;
  logic        standby_q = 1'b1;
  wire         wr_act = !chip_sel_n_in && !write_strobe_n_in;
  wire         drive  = !chip_sel_n_in && write_strobe_n_in && !out_enable_n_in;

  always @(negedge wr_act) begin
    if (!$isunknown(addr_in)) begin
      word = mem.exists(addr_in) ? mem[addr_in] : 16'h0000;
      if (!lower_byte_sel_n_in) word[7:0] = dq_in[7:0];
      if (!upper_byte_sel_n_in) word[15:8] = dq_in[15:8];
      mem[addr_in] = word;
    end
  end

  // Old word stays put for a short while after the address moves
  always @(addr_in) addr_d <= #10 addr_in;
  always @(drive or addr_in) begin
    valid_q <= #10 1'b0;
    valid_q <= #45 drive;
  end
  // Standby lifts at once on select and settles a while after deselect
  always @(negedge chip_sel_n_in) standby_q <= 1'b0;
  always @(posedge chip_sel_n_in) standby_q <= #45 1'b1;

  // A floating bus shows the inverse of the last word, never a lucky match
  always @(addr_d or valid_q or drive or standby_q
           or upper_byte_sel_n_in or lower_byte_sel_n_in) begin
    dq_out = ~last_q;
    if (drive && valid_q && !standby_q && mem.exists(addr_d)) begin
      if (!lower_byte_sel_n_in) dq_out[7:0] = mem[addr_d][7:0];
      if (!upper_byte_sel_n_in) dq_out[15:8] = mem[addr_d][15:8];
      last_q = dq_out;
    end
  end
endmodule

`default_nettype wire

// ==== verif/asc_host_tb.sv ====
`timescale 1ns/100ps
`default_nettype none

module asc_host_tb;
  typedef struct {
    logic        w;
    logic [17:0] a;
    logic [15:0] d;
    logic [1:0]  l;
    logic [15:0] e;
  } asc_row_t;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        vld = 1'b0;
  logic        wr = 1'b0;
  logic [17:0] addr = 18'h00000;
  logic [15:0] wdat = 16'h0000;
  logic [1:0]  lanes = 2'h0;
  logic        rdy, rsp_vld, cs_n, we_n, oe_n, ub_n, lb_n, h_oe;
  logic [15:0] rdata, h_dout, s_dout;
  logic [17:0] m_addr;
  wire  [15:0] bus = h_oe ? h_dout : s_dout;
  int          error_cnt = 0;
  int          n_tests = 0;
  asc_row_t    rows [8] = '{
    '{1'b1, 18'h00000, 16'h1234, 2'h3, 16'h0000},
    '{1'b0, 18'h00000, 16'h0000, 2'h3, 16'h1234},
    '{1'b1, 18'h3FFFF, 16'hABCD, 2'h1, 16'h0000},
    '{1'b1, 18'h3FFFF, 16'h5600, 2'h2, 16'h0000},
    '{1'b0, 18'h3FFFF, 16'h0000, 2'h1, 16'h00CD},
    '{1'b0, 18'h3FFFF, 16'h0000, 2'h3, 16'h56CD},
    '{1'b0, 18'h00000, 16'h0000, 2'h2, 16'h1200},
    '{1'b0, 18'h3FFFF, 16'h0000, 2'h2, 16'h5600}};

  always #25 clk = ~clk;

  asc_host dut (.ref_clk_in(clk), .reset_in(rst), .req_valid_in(vld), .req_write_in(wr),
    .req_addr_in(addr), .req_wdata_in(wdat), .req_lanes_in(lanes), .req_ready_out(rdy),
    .rsp_valid_out(rsp_vld), .rsp_rdata_out(rdata), .mem_addr_out(m_addr),
    .chip_sel_n_out(cs_n), .write_strobe_n_out(we_n), .out_enable_n_out(oe_n),
    .upper_byte_sel_n_out(ub_n), .lower_byte_sel_n_out(lb_n), .mem_data_in(bus),
    .mem_data_out(h_dout), .mem_data_oe_out(h_oe));

  asc_sram_model sram (.addr_in(m_addr), .chip_sel_n_in(cs_n), .write_strobe_n_in(we_n),
    .out_enable_n_in(oe_n), .upper_byte_sel_n_in(ub_n), .lower_byte_sel_n_in(lb_n),
    .dq_in(bus), .dq_out(s_dout));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic idle_pins();
    check("idle pins", 32'h1F, {cs_n, we_n, oe_n, ub_n, lb_n});
    check("host drive", 32'h0, h_oe);
  endtask

  // Valid is held while ready is low, so a refused request is simply retried
  task automatic req(input asc_row_t r);
    int k;
    k = 0;
    @(posedge clk);
    vld <= 1'b1;
    wr <= r.w;
    addr <= r.a;
    wdat <= r.d;
    lanes <= r.l;
    do begin @(negedge clk); k++; end while (rdy !== 1'b1 && k < 40);
    check("ready wait", 32'h1, rdy);
    @(posedge clk);
    vld <= 1'b0;
    if (!r.w) begin
      k = 0;
      do begin @(negedge clk); k++; end while (rsp_vld !== 1'b1 && k < 9);
      check("read latency", 32'd5, k);
      check("read data", r.e, rdata);
    end
  endtask

  initial begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end

  initial begin
    repeat (7) @(posedge clk);
    @(negedge clk);
    idle_pins();
    check("ready in reset", 32'h0, rdy);
    @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) req(rows[i]);
    // Empty lane mask must leave the bus untouched
    @(posedge clk);
    vld <= 1'b1;
    wr <= 1'b1;
    wdat <= 16'hFFFF;
    addr <= 18'h00000;
    lanes <= 2'h0;
    repeat (3) @(negedge clk);
    check("no lanes", 32'h1, cs_n);
    @(posedge clk);
    vld <= 1'b0;
    req('{1'b0, 18'h00000, 16'h0000, 2'h3, 16'h1234});
    // Reset in mid write drops every strobe at once
    req('{1'b1, 18'h00001, 16'h7777, 2'h3, 16'h0000});
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    idle_pins();
    @(posedge clk);
    rst <= 1'b0;
    req('{1'b0, 18'h3FFFF, 16'h0000, 2'h3, 16'h56CD});
    give_verdict();
  end
endmodule

`default_nettype wire
